// >>> inc/fsp_regs.svh
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
`define FSP_ADDR_W        24
`define FSP_SA_W          9
`define FSP_SA_LSB        15
`define FSP_DATA_W        8
`define FSP_SA_FIRST      9'h000
`define FSP_SA_LAST       9'h1FF
`define FSP_SA_END_MASK   9'h1FC
`define FSP_SA_GROUP_MASK 9'h1FC
`define FSP_UNLK1_ADDR    24'h000AAA
`define FSP_UNLK2_ADDR    24'h000555
`define FSP_UNLK1_DATA    8'hAA
`define FSP_UNLK2_DATA    8'h55
`define FSP_CMD_ENTER_ID  8'h88
`define FSP_CMD_EXIT_ID   8'h90
`define FSP_CMD_EXIT_ID2  8'h00
`define FSP_CMD_AUTOSEL   8'h90
`define FSP_CMD_RESET     8'hF0
`define FSP_CMD_PROT      8'h60
`define FSP_PROT_ADDR_LO  24'h000002
`define FSP_UNPROT_ADDR   24'h000042
`define FSP_GRP_ONE       9'h001
`define FSP_GRP_SPAN      9'h004
`define FSP_IND_OFFS      24'h000006
`define FSP_IND_BIT       7
`define FSP_PROT_BIT      0
`define FSP_CYC_W         4
`define FSP_CYC_HOLD      4'h3
`define FSP_IDREG_BYTES   256
`define FSP_ESN_LAST      24'h000007
`endif

// >>> inc/fsp_pkg.sv
package fsp_pkg;
    typedef enum logic [3:0] {
        FSP_IDLE   = 4'h0,
        FSP_ISSUE  = 4'h1,
        FSP_HOLD   = 4'h3,
        FSP_GAP    = 4'h2,
        FSP_NEXT   = 4'h6,
        FSP_DONE   = 4'h7
    } fsp_state_t;
    typedef enum logic [2:0] {
        FSP_OP_ENTER_ID  = 3'h0,
        FSP_OP_EXIT_ID   = 3'h1,
        FSP_OP_LOCK_ID   = 3'h2,
        FSP_OP_READ_IND  = 3'h3,
        FSP_OP_VERIFY    = 3'h4,
        FSP_OP_READ      = 3'h5,
        FSP_OP_WRITE     = 3'h6,
        FSP_OP_UNPROT    = 3'h7
    } fsp_op_t;
endpackage : fsp_pkg

// >>> inc/fsp_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fsp_bus_if;
    logic        start;
    logic        is_write;
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
    modport master (output start, is_write, addr, wdata, input busy, done, rdata);
    modport slave  (input start, is_write, addr, wdata, output busy, done, rdata);
endinterface : fsp_bus_if
`default_nettype wire

// >>> logic/fsp_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"
module fsp_cycle (
    input  wire logic       clock,
    input  wire logic       rst_n,
    fsp_bus_if.slave        bus,
    output logic            ce_n,
    output logic            oe_n,
    output logic            we_n,
    output logic [23:0]     a,
    output logic [7:0]      dq_o,
    output logic            dq_oe,
    input  wire logic [7:0] dq_i
);
    import fsp_pkg::*;
    logic [3:0] cnt_reg;
    logic       act_reg;
    logic       wr_reg;
    logic       done_reg;
    logic [7:0] rd_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            act_reg  <= 1'b0;
            wr_reg   <= 1'b0;
            cnt_reg  <= 4'h0;
            a        <= 24'h000000;
            dq_o     <= 8'h00;
        end else if (!act_reg && bus.start) begin
            act_reg  <= 1'b1;
            wr_reg   <= bus.is_write;
            cnt_reg  <= `FSP_CYC_HOLD;
            a        <= bus.addr;
            dq_o     <= bus.wdata;
        end else if (act_reg) begin
            if (cnt_reg == 4'h0) begin
                act_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
            rd_reg   <= 8'h00;
        end else begin
            done_reg <= act_reg && (cnt_reg == 4'h0);
            if (act_reg && !wr_reg && cnt_reg == 4'h0) begin
                rd_reg <= dq_i;
            end
        end
    end

    // strobes low only while a cycle is active; write releases we_n one cycle early
    assign ce_n      = !act_reg;
    assign oe_n      = !(act_reg && !wr_reg);
    assign we_n      = !(act_reg && wr_reg && cnt_reg != 4'h0);
    assign dq_oe     = act_reg && wr_reg;
    assign bus.busy  = act_reg;
    assign bus.done  = done_reg;
    assign bus.rdata = rd_reg;
endmodule : fsp_cycle
`default_nettype wire

// >>> logic/fsp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"
module fsp_ctrl (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 op_valid,
    input  wire fsp_pkg::fsp_op_t     op_code,
    input  wire logic [23:0]          op_addr,
    input  wire logic [7:0]           op_wdata,
    output logic                      op_ready,
    output logic                      op_done,
    output logic [7:0]                op_rdata,
    output logic                      op_refused,
    output logic                      id_mapped,
    output logic                      group_prot,
    output logic                      factory_locked,
    input  wire logic                 temp_unprot,
    input  wire logic                 guard_low,
    output logic                      ce_n,
    output logic                      oe_n,
    output logic                      we_n,
    output logic [23:0]               a,
    output logic [7:0]                dq_o,
    output logic                      dq_oe,
    input  wire logic [7:0]           dq_i,
    output logic                      write_guard_accel_pin_o,
    output logic                      write_guard_accel_pin_oe,
    output logic                      reset_elevated_req
);
    import fsp_pkg::*;

    fsp_bus_if bus ();
    fsp_cycle u_cycle (
        .clock (clock),
        .rst_n (rst_n),
        .bus   (bus),
        .ce_n  (ce_n),
        .oe_n  (oe_n),
        .we_n  (we_n),
        .a     (a),
        .dq_o  (dq_o),
        .dq_oe (dq_oe),
        .dq_i  (dq_i)
    );

    fsp_state_t state_reg;
    fsp_op_t    op_reg;
    logic [23:0] addr_reg;
    logic [7:0]  wdata_reg;
    logic [2:0]  step_reg;
    logic [2:0]  nsteps;
    logic        id_reg;
    logic        done_reg;
    logic        refused_reg;
    logic [7:0]  rdata_reg;
    logic        is_write;
    logic [23:0] step_addr;
    logic [7:0]  step_data;
    logic [8:0]  sweep_reg;
    logic        final_reg;

    function automatic logic [8:0] sa_of(input logic [23:0] ad);
        sa_of = ad[`FSP_SA_LSB +: `FSP_SA_W];
    endfunction : sa_of

    // the first four and last four sectors protect alone, the rest in groups of four
    function automatic logic end_group(input logic [8:0] sa);
        end_group = ((sa & `FSP_SA_END_MASK) == `FSP_SA_FIRST)
                 || ((sa & `FSP_SA_END_MASK) == `FSP_SA_END_MASK);
    endfunction : end_group

    function automatic logic [8:0] group_of(input logic [8:0] sa);
        group_of = end_group(sa) ? sa : (sa & `FSP_SA_GROUP_MASK);
    endfunction : group_of

    function automatic logic [8:0] next_group(input logic [8:0] sa);
        next_group = end_group(sa) ? sa + `FSP_GRP_ONE : sa + `FSP_GRP_SPAN;
    endfunction : next_group

    function automatic logic is_end_sector(input logic [8:0] sa);
        is_end_sector = (sa == `FSP_SA_FIRST) || (sa == `FSP_SA_LAST);
    endfunction : is_end_sector

    // sequence of bus cycles per operation
    always_comb begin
        nsteps    = 3'h1;
        is_write  = 1'b1;
        step_addr = `FSP_UNLK1_ADDR;
        step_data = `FSP_UNLK1_DATA;
        case (op_reg)
            FSP_OP_ENTER_ID, FSP_OP_EXIT_ID, FSP_OP_READ_IND: begin
                nsteps = (op_reg == FSP_OP_EXIT_ID) ? 3'h4 : 3'h3;
                if (op_reg == FSP_OP_READ_IND) begin
                    nsteps = 3'h4;
                end
                case (step_reg)
                    3'h0: begin
                        step_addr = `FSP_UNLK1_ADDR;
                        step_data = `FSP_UNLK1_DATA;
                    end
                    3'h1: begin
                        step_addr = `FSP_UNLK2_ADDR;
                        step_data = `FSP_UNLK2_DATA;
                    end
                    3'h2: begin
                        step_addr = `FSP_UNLK1_ADDR;
                        step_data = (op_reg == FSP_OP_ENTER_ID) ? `FSP_CMD_ENTER_ID
                                  : (op_reg == FSP_OP_EXIT_ID) ? `FSP_CMD_EXIT_ID
                                  : `FSP_CMD_AUTOSEL;
                    end
                    default: begin
                        step_addr = (op_reg == FSP_OP_READ_IND) ? `FSP_IND_OFFS : 24'h000000;
                        step_data = `FSP_CMD_EXIT_ID2;
                        is_write  = (op_reg != FSP_OP_READ_IND);
                    end
                endcase
            end
            FSP_OP_LOCK_ID: begin
                nsteps    = 3'h1;
                step_addr = addr_reg;
                step_data = `FSP_CMD_PROT;
            end
            FSP_OP_VERIFY: begin
                nsteps    = 3'h1;
                is_write  = 1'b0;
                step_addr = {group_of(sa_of(addr_reg)), 15'h0000} | `FSP_PROT_ADDR_LO;
            end
            FSP_OP_READ: begin
                is_write  = 1'b0;
                step_addr = addr_reg;
            end
            FSP_OP_WRITE: begin
                step_addr = addr_reg;
                step_data = wdata_reg;
            end
            FSP_OP_UNPROT: begin
                // protect every group first, then one unprotect write clears all
                step_addr = final_reg ? `FSP_UNPROT_ADDR
                          : ({sweep_reg, 15'h0000} | `FSP_PROT_ADDR_LO);
                step_data = `FSP_CMD_PROT;
            end
            default: begin
                nsteps = 3'h1;
            end
        endcase
    end

    // lock only legal with region mapped; main array writes refused while mapped
    logic refuse_now;
    assign refuse_now = (op_code == FSP_OP_LOCK_ID && !id_reg)
                     || (op_code == FSP_OP_ENTER_ID && id_reg)
                     || (op_code == FSP_OP_UNPROT && (id_reg || !temp_unprot));
    logic wr_idle_ok;
    assign wr_idle_ok = !(id_reg && op_code == FSP_OP_WRITE
                          && sa_of(op_addr) != `FSP_SA_FIRST);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= FSP_IDLE;
            step_reg  <= 3'h0;
            op_reg    <= FSP_OP_READ;
            addr_reg  <= 24'h000000;
            wdata_reg <= 8'h00;
        end else begin
            case (state_reg)
                FSP_IDLE: begin
                    if (op_valid && !refuse_now && wr_idle_ok) begin
                        op_reg    <= op_code;
                        addr_reg  <= op_addr;
                        wdata_reg <= op_wdata;
                        step_reg  <= 3'h0;
                        state_reg <= FSP_ISSUE;
                    end
                end
                FSP_ISSUE: state_reg <= FSP_HOLD;
                FSP_HOLD: begin
                    if (bus.done) begin
                        state_reg <= FSP_GAP;
                    end
                end
                FSP_GAP: begin
                    if (op_reg == FSP_OP_UNPROT && !final_reg) begin
                        state_reg <= FSP_NEXT;
                    end else if (step_reg + 3'h1 >= nsteps) begin
                        state_reg <= FSP_DONE;
                    end else begin
                        step_reg  <= step_reg + 3'h1;
                        state_reg <= FSP_NEXT;
                    end
                end
                FSP_NEXT: state_reg <= FSP_ISSUE;
                FSP_DONE: state_reg <= FSP_IDLE;
                default:  state_reg <= FSP_IDLE;
            endcase
        end
    end

    // group sweep walks every group base, end sectors singly
    always_ff @(posedge clock) begin
        if (!rst_n || state_reg == FSP_IDLE) begin
            sweep_reg <= `FSP_SA_FIRST;
            final_reg <= 1'b0;
        end else if (state_reg == FSP_GAP && op_reg == FSP_OP_UNPROT && !final_reg) begin
            if (sweep_reg == `FSP_SA_LAST) begin
                final_reg <= 1'b1;
            end else begin
                sweep_reg <= next_group(sweep_reg);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            id_reg <= 1'b0;
        end else if (state_reg == FSP_DONE && op_reg == FSP_OP_ENTER_ID) begin
            id_reg <= 1'b1;
        end else if (state_reg == FSP_DONE && op_reg == FSP_OP_EXIT_ID) begin
            id_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_reg      <= 8'h00;
            group_prot     <= 1'b0;
            factory_locked <= 1'b0;
        end else if (state_reg == FSP_GAP && !is_write) begin
            rdata_reg <= bus.rdata;
            if (op_reg == FSP_OP_VERIFY) begin
                group_prot <= bus.rdata != 8'h00;
            end
            if (op_reg == FSP_OP_READ_IND) begin
                factory_locked <= bus.rdata[`FSP_IND_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_reg    <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            done_reg    <= state_reg == FSP_DONE;
            refused_reg <= state_reg == FSP_IDLE && op_valid && (refuse_now || !wr_idle_ok);
        end
    end

    assign bus.start    = state_reg == FSP_ISSUE;
    assign bus.is_write = is_write;
    assign bus.addr     = step_addr;
    assign bus.wdata    = step_data;

    assign op_ready   = state_reg == FSP_IDLE;
    assign op_done    = done_reg;
    assign op_refused = refused_reg;
    assign op_rdata   = rdata_reg;
    assign id_mapped  = id_reg;

    // guard pin: drive low to block end sectors, else release to pull-up
    assign write_guard_accel_pin_o  = 1'b0;
    assign write_guard_accel_pin_oe = guard_low;
    assign reset_elevated_req       = temp_unprot;
endmodule : fsp_ctrl
`default_nettype wire

// >>> tb/fsp_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_props (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic             op_valid,
    input wire fsp_pkg::fsp_op_t op_code,
    input wire logic [23:0]      op_addr,
    input wire logic             op_ready,
    input wire logic             op_refused,
    input wire logic             id_mapped,
    input wire logic             guard_low,
    input wire logic             temp_unprot,
    input wire logic             ce_n,
    input wire logic             oe_n,
    input wire logic             we_n,
    input wire logic             dq_oe,
    input wire logic             write_guard_accel_pin_o,
    input wire logic             write_guard_accel_pin_oe,
    input wire logic             reset_elevated_req
);
    import fsp_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence take_s(fsp_op_t c);
        op_valid && op_ready && op_code == c;
    endsequence
    sequence wr_pulse_s;
        (!we_n && !ce_n)[*3] ##1 we_n;
    endsequence
    guard_pin_a: assert property (
        write_guard_accel_pin_oe == guard_low && !write_guard_accel_pin_o)
        else $error("guard pin wrong");
    elev_req_a: assert property (reset_elevated_req == temp_unprot)
        else $error("elevated request wrong");
    wr_pulse_a: assert property ($fell(we_n) |-> wr_pulse_s)
        else $error("write pulse length wrong");
    wr_inhibit_a: assert property (!we_n |-> oe_n && !ce_n && dq_oe)
        else $error("write strobes wrong");
    rd_release_a: assert property (!oe_n |-> we_n && !ce_n && !dq_oe)
        else $error("read strobes wrong");
    lock_refuse_a: assert property (
        take_s(FSP_OP_LOCK_ID) ##0 !id_mapped |-> ##[1:2] op_refused)
        else $error("lock not refused");
    enter_refuse_a: assert property (
        take_s(FSP_OP_ENTER_ID) ##0 id_mapped |-> ##[1:2] op_refused)
        else $error("enter not refused");
    wr_refuse_a: assert property (
        take_s(FSP_OP_WRITE) ##0 (id_mapped && op_addr[23:15] != 9'h000)
        |-> ##[1:2] op_refused) else $error("write not refused");
    unprot_refuse_a: assert property (
        take_s(FSP_OP_UNPROT) ##0 !temp_unprot |-> ##[1:2] op_refused)
        else $error("unprotect not refused");
    rst_idle_a: assert property (
        $rose(rst_n) |-> !id_mapped && ce_n && we_n && !dq_oe)
        else $error("reset state wrong");
endmodule : fsp_ctrl_props
bind fsp_ctrl fsp_ctrl_props chk_u (.clock, .rst_n, .op_valid, .op_code, .op_addr,
    .op_ready, .op_refused, .id_mapped, .guard_low, .temp_unprot, .ce_n, .oe_n, .we_n,
    .dq_oe, .write_guard_accel_pin_o, .write_guard_accel_pin_oe, .reset_elevated_req);
`default_nettype wire

// >>> tb/fsp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"
module fsp_flash_model #(
    parameter logic       FACT_LOCK = 1'b0,
    parameter logic [7:0] MFR_CODE  = 8'h5C, // arbitrary value
    parameter int         RD_DLY    = 0
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [23:0] a,
    input  wire logic [7:0]  dq_o,
    input  wire logic        dq_oe,
    output wire logic [7:0]  dq_i,
    input  wire logic        wp_pin,
    input  wire logic        elev,
    input  wire logic        hw_rst_n
);
    logic [7:0] mem [bit [23:0]];
    logic [7:0] idmem [256];
    logic       gprot [512];
    logic       idmap, autosel, prog, xpend, byp, unprot_err;
    logic       idlock = FACT_LOCK;
    logic [1:0] ulk;
    logic [7:0] rv, last;
    wire logic [8:0] sa = a[23:15];
    function automatic logic [8:0] gk(input logic [8:0] s);
        return (s < 9'h004 || s > 9'h1FB) ? s : (s & 9'h1FC);
    endfunction : gk
    function automatic logic blk(input logic [8:0] s);
        return (gprot[gk(s)] && !elev) || (!wp_pin && (s == 9'h000 || s == 9'h1FF));
    endfunction : blk
    initial begin
        last = 8'h00;
        {idmap, autosel, prog, xpend, byp, unprot_err} = 6'h00;
        ulk = 2'h0;
        foreach (gprot[i]) gprot[i] = 1'b0;
        foreach (idmem[i]) idmem[i] = 8'hFF;
        if (FACT_LOCK) for (int i = 0; i < 8; i++) idmem[i] = MFR_CODE ^ 8'(i);
    end
    always @(negedge hw_rst_n) begin
        {idmap, autosel, prog, xpend, byp} = 5'h00;
        ulk = 2'h0;
    end
    // address and data settle with the strobe; take them just after it falls
    always @(negedge we_n) begin
        #5;
        if (!ce_n && dq_oe) begin
            if (prog) begin
                prog = 1'b0;
                if (idmap && sa == 9'h000) begin
                    if (!idlock) idmem[a[7:0]] = idmem[a[7:0]] & dq_o;
                end else if (!blk(sa)) begin
                    mem[a] = (mem.exists(a) ? mem[a] : 8'hFF) & dq_o;
                end
            end else if (ulk == 2'h2 && a == `FSP_UNLK1_ADDR) begin
                ulk = 2'h0;
                prog = (dq_o == 8'hA0);
                byp = byp || (dq_o == 8'h20 && !idmap);
                if (dq_o == `FSP_CMD_ENTER_ID) {idmap, autosel} = 2'b10;
                if (dq_o == `FSP_CMD_AUTOSEL) {xpend, autosel} = {idmap, !idmap};
            end else if (dq_o == `FSP_UNLK1_DATA && a == `FSP_UNLK1_ADDR) ulk = 2'h1;
            else if (dq_o == `FSP_UNLK2_DATA && ulk == 2'h1) ulk = 2'h2;
            else begin
                ulk = 2'h0;
                if (dq_o == `FSP_CMD_EXIT_ID2 && xpend) idmap = 1'b0;
                if (dq_o == `FSP_CMD_RESET) autosel = 1'b0;
                if (dq_o == `FSP_CMD_PROT && idmap) idlock = 1'b1;
                if (dq_o == 8'hA0 && byp && !idmap) prog = 1'b1;
                if (dq_o == `FSP_CMD_PROT && !idmap && elev) begin
                    if (a[6]) begin
                        foreach (gprot[i]) if (!gprot[gk(9'(i))]) unprot_err = 1'b1;
                        foreach (gprot[i]) gprot[i] = 1'b0;
                    end else gprot[gk(sa)] = 1'b1;
                end
                xpend = 1'b0;
            end
        end
    end
    always @(a, ce_n, oe_n, autosel, idmap) begin
        if (autosel) begin
            rv = (a[7:0] == 8'h06) ? {FACT_LOCK, 7'h00} :
                 (a[7:0] == 8'h02) ? {7'h00, gprot[gk(sa)]} : MFR_CODE;
        end else if (idmap && sa == 9'h000) rv = idmem[a[7:0]];
        else rv = mem.exists(a) ? mem[a] : 8'hFF;
        if (!ce_n && !oe_n) last = rv;
    end
    // released bus shows the inverse of the last byte, never a steady copy
    assign #(RD_DLY) dq_i = (!ce_n && !oe_n) ? rv : ~last;
endmodule : fsp_flash_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"
module testbench;
    import fsp_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, op_valid = 1'b0, temp_unprot = 1'b0, guard_low = 1'b0;
    fsp_op_t     op_code  = FSP_OP_READ;
    logic [23:0] op_addr  = 24'h000000;
    logic [7:0]  op_wdata = 8'h00;
    wire logic op_ready, op_done, op_refused, id_mapped, group_prot, factory_locked;
    wire logic ce_n, oe_n, we_n, dq_oe, wg_o, wg_oe, elev;
    wire logic [23:0] a;
    wire logic [7:0]  op_rdata, dq_o, dq_i;
    wire logic wp_pin = wg_oe ? wg_o : 1'b1;
    int err_total = 0, total_checks = 0, cyc = 0;
    logic rf;
    logic [7:0] d;
    logic [8:0] s;
    always #20 clock = ~clock;
    fsp_ctrl dut_u (.clock, .rst_n, .op_valid, .op_code, .op_addr, .op_wdata, .op_ready,
        .op_done, .op_rdata, .op_refused, .id_mapped, .group_prot, .factory_locked,
        .temp_unprot, .guard_low, .ce_n, .oe_n, .we_n, .a, .dq_o, .dq_oe, .dq_i,
        .write_guard_accel_pin_o(wg_o), .write_guard_accel_pin_oe(wg_oe),
        .reset_elevated_req(elev));
    fsp_flash_model #(.RD_DLY(70)) flash_u (.ce_n, .oe_n, .we_n, .a, .dq_o, .dq_oe, .dq_i,
        .wp_pin, .elev, .hw_rst_n(rst_n));
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic op(input fsp_op_t c, input logic [23:0] ad, input logic [7:0] wd);
        int n;
        @(posedge clock);
        #1;
        {op_valid, op_code, op_addr, op_wdata} = {1'b1, c, ad, wd};
        @(posedge clock);
        #1;
        op_valid = 1'b0;
        for (n = 0; n < 2000 && op_done !== 1'b1 && op_refused !== 1'b1; n++) @(posedge clock) #1;
        rf = op_refused;
        if (n == 2000) chk(8'h00, 8'h01, "op hang");
    endtask : op
    task automatic cmd(input logic [7:0] c);
        op(FSP_OP_WRITE, `FSP_UNLK1_ADDR, `FSP_UNLK1_DATA);
        op(FSP_OP_WRITE, `FSP_UNLK2_ADDR, `FSP_UNLK2_DATA);
        op(FSP_OP_WRITE, `FSP_UNLK1_ADDR, c);
    endtask : cmd
    task automatic prog(input logic [23:0] ad, input logic [7:0] v);
        cmd(8'hA0);
        op(FSP_OP_WRITE, ad, v);
    endtask : prog
    task automatic rd(input logic [23:0] ad, input logic [7:0] e, input string m);
        op(FSP_OP_READ, ad, 8'h00);
        chk(op_rdata, e, m);
    endtask : rd
    task automatic vfy(input logic [8:0] sec, input logic e, input string m);
        cmd(`FSP_CMD_AUTOSEL);
        op(FSP_OP_VERIFY, {sec, 15'h0000}, 8'h00);
        op(FSP_OP_WRITE, 24'h000000, `FSP_CMD_RESET);
        chk(group_prot, e, m);
    endtask : vfy
    initial begin
        void'($urandom(32'h308C0D41));
        repeat (16) @(posedge clock);
        #1 rst_n = 1'b1;
        chk({ce_n, we_n, oe_n, id_mapped, dq_oe}, 8'h1C, "reset state");
        repeat (8) begin
            @(posedge clock) #1 {guard_low, temp_unprot} = 2'($urandom);
            #1 chk({wp_pin, elev}, {!guard_low, temp_unprot}, "pin levels");
        end
        {guard_low, temp_unprot} = 2'b00;
        op(FSP_OP_READ_IND, 24'h000000, 8'h00);
        chk(factory_locked, 1'b0, "indicator");
        op(FSP_OP_LOCK_ID, 24'h000000, 8'h00);
        chk(rf, 1'b1, "lock unmapped");
        op(FSP_OP_ENTER_ID, 24'h000000, 8'h00);
        chk({rf, id_mapped}, 2'b01, "enter");
        op(FSP_OP_ENTER_ID, 24'h000000, 8'h00);
        chk(rf, 1'b1, "enter twice");
        op(FSP_OP_WRITE, {9'($urandom_range(1, 511)), 15'h0000}, 8'h00);
        chk(rf, 1'b1, "write outside");
        d = 8'($urandom) | 8'h01;
        prog(24'h000010, d);
        rd(24'h000010, d, "id program");
        op(FSP_OP_LOCK_ID, 24'h000000, 8'h00);
        chk(rf, 1'b0, "lock");
        prog(24'h000010, 8'h00);
        rd(24'h000010, d, "id locked");
        op(FSP_OP_EXIT_ID, 24'h000000, 8'h00);
        chk(id_mapped, 1'b0, "exit");
        rd(24'h000010, 8'hFF, "array back");
        s = 9'($urandom_range(4, 507));
        flash_u.gprot[s & 9'h1FC] = 1'b1;
        vfy(s ^ 9'h003, 1'b1, "group of four");
        vfy(9'h002, 1'b0, "shipped clear");
        d = 8'($urandom) & 8'hFE;
        prog({s, 15'h0040}, d);
        rd({s, 15'h0040}, 8'hFF, "blocked");
        temp_unprot = 1'b1;
        prog({s, 15'h0040}, d);
        rd({s, 15'h0040}, d, "temp unprotect");
        temp_unprot = 1'b0;
        vfy(s, 1'b1, "protect restored");
        {guard_low, temp_unprot} = 2'b11;
        prog(24'hFF8020, d);
        rd(24'hFF8020, 8'hFF, "guard blocks");
        {guard_low, temp_unprot} = 2'b00;
        prog(24'hFF8020, d);
        rd(24'hFF8020, d, "guard released");
        op(FSP_OP_UNPROT, 24'h000000, 8'h00);
        chk(rf, 1'b1, "unprotect needs level");
        temp_unprot = 1'b1;
        op(FSP_OP_UNPROT, 24'h000000, 8'h00);
        temp_unprot = 1'b0;
        chk(rf, 1'b0, "unprotect");
        chk(flash_u.unprot_err, 1'b0, "all protected first");
        vfy(s, 1'b0, "all groups clear");
        prog({s, 15'h0080}, d);
        rd({s, 15'h0080}, d, "writable again");
        op(FSP_OP_ENTER_ID, 24'h000000, 8'h00);
        @(posedge clock) #1 rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        chk(id_mapped, 1'b0, "reset unmaps");
        rd(24'h000010, 8'hFF, "normal sector");
        conclude();
    end
endmodule : testbench
`default_nettype wire
